// ---- mbx_exc_scale.sv ----
// Notes on behaviour
// - Decimal values exchanged as value times ten^n
// - Writes divided by scale, reads multiplied back
// - Good request echoes function code unchanged
// - Failed request sets function code top bit
// - Exception: address, code, error byte, CRC
// - Unknown function or fault state gives 01H
// - Malformed data field gives 03H
// - Out-of-range parameter setting gives 04H
// - Wrong password at check address gives 05H
// - Bad length or CRC gives 06H
// - Write to read-only parameter gives 07H
// - Run-locked write while running gives 08H
// - Locked by password gives 09H
//
// Purpose: checks a decoded request, scales data, emits the reply bytes
// Assumes: frame bytes and decoded request arrive from a receiver
// Notes:   reply leaves at most one byte every two cycles under byte_rdy_in
`timescale 1ns/1ps
`default_nettype none
module mbx_exc_scale
  import mbx_pkg::*;
#(
  parameter int MAX_QTY = 12
)
(
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        rx_start_in,
  input  wire logic        rx_byte_vld_in,
  input  wire logic [7:0]  rx_byte_in,
  input  wire logic        req_vld_in,
  input  wire mbx_req_s    req_in,
  input  wire mbx_par_s    par_in,
  input  wire logic        fault_in,
  input  wire logic        running_in,
  input  wire logic [15:0] user_password_setting_in,
  input  wire logic        byte_rdy_in,
  output logic             busy_out,
  output logic             byte_vld_out,
  output logic      [7:0]  byte_out,
  output logic             reply_done_out,
  output mbx_wr_s          wr_out,
  output logic      [7:0]  err_out
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_CHECK = 3'b010,
    ST_SEND  = 3'b100
  } mbx_state_e;

  mbx_state_e  state;
  mbx_req_s    req;
  mbx_par_s    par;
  logic [7:0]  err;
  logic [7:0]  next_err;
  logic [15:0] rd_val;
  logic [15:0] next_rd;
  logic [15:0] wr_val;
  logic [3:0]  idx;
  logic [3:0]  tx_len;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  logic [15:0] crc_hold;
  logic [7:0]  tx_byte;
  logic        unlocked;
  logic        is_read;
  logic        is_write;
  logic        func_ok;
  logic        fire;
  logic        ld_wait;
  logic [15:0] pow10;
  logic [31:0] prod;

  // Receive side CRC over the whole frame, residue zero when intact
  mbx_crc u_rx_crc (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n_in),
    .start_in    (rx_start_in),
    .byte_vld_in (rx_byte_vld_in),
    .byte_in     (rx_byte_in),
    .crc_out     (rx_crc)
  );

  // Transmit side CRC over the reply bytes already sent
  mbx_crc u_tx_crc (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n_in),
    .start_in    (state == ST_CHECK),
    .byte_vld_in (fire && idx < tx_len - 4'h2),
    .byte_in     (tx_byte),
    .crc_out     (tx_crc)
  );

  assign is_read  = (req.func == FC_READ);
  assign is_write = (req.func == FC_WRITE);
  assign func_ok  = is_read || is_write;
  assign fire     = byte_vld_out && byte_rdy_in;

  // Scale m = 10^n, n from the parameter's decimal places
  always_comb begin
    pow10 = 16'h0001;
    for (int i = 0; i < SCALE_MAX_DEC; i++) begin
      if (i < par.decimals) begin
        pow10 = 16'(pow10 * 16'h000a);
      end
    end
  end

  // The stored form is the engineering value; the bus form is times m
  assign prod    = 32'(par.stored) * 32'(pow10);
  assign next_rd = prod[15:0];
  assign wr_val  = 16'(req.data / pow10);

  // Priority: frame first, then function, lock, address, data, write checks
  always_comb begin
    next_err = EC_NONE;
    if (rx_crc != RESET_WORD || !(req.len == ECHO_LEN)) begin
      next_err = EC_FRAME;
    end else if (!func_ok || fault_in) begin
      next_err = EC_BAD_FUNC;
    end else if (user_password_setting_in != RESET_WORD && !unlocked && !par.pwd_addr) begin
      next_err = EC_SYS_LOCKED;
    end else if (!par.addr_ok || (is_read && 32'(req.data) > 32'(MAX_QTY))) begin
      next_err = EC_BAD_ADDR;
    end else if (is_read && req.data == RESET_WORD) begin
      next_err = EC_BAD_DATA;
    end else if (is_write && par.pwd_addr) begin
      if (req.data != user_password_setting_in) begin
        next_err = EC_PASSWORD;
      end
    end else if (is_write && par.read_only) begin
      next_err = EC_READ_ONLY;
    end else if (is_write && par.run_locked && running_in) begin
      next_err = EC_RUN_LOCK;
    end else if (is_write && !par.range_ok) begin
      next_err = EC_OP_FAIL;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE:  state <= req_vld_in ? ST_CHECK : ST_IDLE;
        ST_CHECK: state <= ST_SEND;
        ST_SEND:  state <= (fire && idx == tx_len - 4'h1) ? ST_IDLE : ST_SEND;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      req <= '0;
      par <= '0;
    end else if (state == ST_IDLE && req_vld_in) begin
      req <= req_in;
      par <= par_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      err    <= EC_NONE;
      rd_val <= RESET_WORD;
      tx_len <= RESET_CNT;
    end else if (state == ST_CHECK) begin
      err    <= next_err;
      rd_val <= next_rd;
      // Exception frames hold no data field
      tx_len <= (next_err != EC_NONE) ? EXC_LEN : (is_read ? READ_LEN : ECHO_LEN);
    end
  end

  // Unlock lasts until reset; a later wrong password does not relock
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      unlocked <= 1'b0;
    end else if (state == ST_CHECK && next_err == EC_NONE && is_write && par.pwd_addr) begin
      unlocked <= 1'b1;
    end
  end

  // Store only after all checks passed, CRC included
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wr_out <= '0;
    end else begin
      wr_out.store <= (state == ST_CHECK) && next_err == EC_NONE && is_write && !par.pwd_addr;
      wr_out.value <= wr_val;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      idx <= RESET_CNT;
    end else if (state == ST_CHECK) begin
      idx <= RESET_CNT;
    end else if (fire) begin
      idx <= idx + 4'h1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      crc_hold <= CRC_INIT;
    end else if (fire && idx == tx_len - 4'h2) begin
      // Sum is final once the low byte leaves, whatever the drain rate
      crc_hold <= tx_crc;
    end
  end

  // Reply byte by position
  always_comb begin
    tx_byte = RESET_BYTE;
    if (idx == 4'h0) begin
      tx_byte = req.slave;
    end else if (idx == 4'h1) begin
      tx_byte = (err != EC_NONE) ? (req.func | FC_EXC_BIT) : req.func;
    end else if (err != EC_NONE) begin
      tx_byte = (idx == 4'h2) ? err : RESET_BYTE;
    end else if (is_read) begin
      case (idx)
        4'h2:    tx_byte = 8'h02;
        4'h3:    tx_byte = rd_val[15:8];
        4'h4:    tx_byte = rd_val[7:0];
        default: tx_byte = RESET_BYTE;
      endcase
    end else begin
      case (idx)
        4'h2:    tx_byte = req.addr[15:8];
        4'h3:    tx_byte = req.addr[7:0];
        4'h4:    tx_byte = req.data[15:8];
        4'h5:    tx_byte = req.data[7:0];
        default: tx_byte = RESET_BYTE;
      endcase
    end
    // Trailing check word, low byte first
    if (idx == tx_len - 4'h2) begin
      tx_byte = tx_crc[7:0];
    end else if (idx == tx_len - 4'h1) begin
      tx_byte = crc_hold[15:8];
    end
  end

  // Registered byte costs one idle cycle per byte; output stays glitch free
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ld_wait  <= 1'b1;
      byte_out <= RESET_BYTE;
    end else begin
      ld_wait  <= (state == ST_CHECK) || fire;
      byte_out <= tx_byte;
    end
  end

  assign byte_vld_out   = (state == ST_SEND) && !ld_wait;
  assign busy_out       = (state != ST_IDLE);
  assign reply_done_out = fire && idx == tx_len - 4'h1;
  assign err_out        = err;

  a_exc_code_bit: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_SEND && idx == 4'h1 && err != EC_NONE) |-> tx_byte[7] == 1'b1)
    else $error("exception code lacks top bit");
  a_echo_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_SEND && idx == 4'h1 && err == EC_NONE) |-> tx_byte == req.func)
    else $error("function code not echoed");
  a_exc_length: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_SEND && err != EC_NONE) |-> tx_len == EXC_LEN)
    else $error("exception frame length wrong");
  a_crc_store: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_CHECK && rx_crc != RESET_WORD) |=> err == EC_FRAME && !wr_out.store)
    else $error("bad frame accepted");
  a_fault_func: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_CHECK && rx_crc == RESET_WORD && req.len == ECHO_LEN && fault_in)
      |=> err == EC_BAD_FUNC)
    else $error("fault state not reported");
  a_ro_write: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_CHECK && next_err == EC_READ_ONLY) |=> !wr_out.store && err == EC_READ_ONLY)
    else $error("read-only parameter written");
  a_run_lock: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_CHECK && next_err == EC_RUN_LOCK) |-> running_in && par.run_locked)
    else $error("run lock without running");
  a_scaled_read: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_CHECK && par.decimals == 4'h1) |=> rd_val == 16'(par.stored * 16'h000a))
    else $error("read value not scaled");
  a_reply_byte: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    byte_vld_out |-> byte_out == tx_byte)
    else $error("reply byte not presented");
  a_reply_bound: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_CHECK) |=> state == ST_SEND)
    else $error("reply not started");
endmodule // mbx_exc_scale
`default_nettype wire

// ---- mbx_pkg.sv ----
// Purpose: shared constants and carriers for the fieldbus request checker
// Assumes: one 40 MHz clock, synchronous active-low reset
// Notes:   error codes, function codes and CRC constants live here
package mbx_pkg;
  localparam int          CLK_PERIOD_NS  = 25;
  localparam logic [7:0]  FC_READ        = 8'h03;
  localparam logic [7:0]  FC_WRITE       = 8'h06;
  localparam logic [7:0]  FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0]  FC_EXC_BIT     = 8'h80;
  localparam logic [7:0]  EC_NONE        = 8'h00;
  localparam logic [7:0]  EC_BAD_FUNC    = 8'h01;
  localparam logic [7:0]  EC_BAD_ADDR    = 8'h02;
  localparam logic [7:0]  EC_BAD_DATA    = 8'h03;
  localparam logic [7:0]  EC_OP_FAIL     = 8'h04;
  localparam logic [7:0]  EC_PASSWORD    = 8'h05;
  localparam logic [7:0]  EC_FRAME       = 8'h06;
  localparam logic [7:0]  EC_READ_ONLY   = 8'h07;
  localparam logic [7:0]  EC_RUN_LOCK    = 8'h08;
  localparam logic [7:0]  EC_SYS_LOCKED  = 8'h09;
  localparam logic [15:0] CRC_INIT       = 16'hffff;
  localparam logic [15:0] CRC_POLY       = 16'ha001;
  localparam logic [15:0] RESET_WORD     = 16'h0000;
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  localparam logic [3:0]  SCALE_MAX_DEC  = 4'h4;
  localparam logic [3:0]  RESET_CNT      = 4'h0;
  localparam logic [3:0]  EXC_LEN        = 4'h5;
  localparam logic [3:0]  ECHO_LEN       = 4'h8;
  localparam logic [3:0]  READ_LEN       = 4'h7;

  // Decoded request as it arrives from the frame receiver
  typedef struct packed {
    logic [7:0]  slave;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] data;
    logic [15:0] crc_rx;
    logic [3:0]  len;
  } mbx_req_s;

  // Facts about the addressed parameter from the drive side
  typedef struct packed {
    logic        addr_ok;
    logic        read_only;
    logic        run_locked;
    logic        range_ok;
    logic        pwd_addr;
    logic [3:0]  decimals;
    logic [15:0] stored;
  } mbx_par_s;

  typedef struct packed {
    logic [15:0] value;
    logic        store;
  } mbx_wr_s;
endpackage : mbx_pkg

// ---- mbx_crc.sv ----
// Purpose: bytewise 16-bit fieldbus CRC, one byte per cycle
// Assumes: bytes of a frame arrive in order, start clears the sum
// Notes:   loop over eight bit steps unrolled in one cycle
`timescale 1ns/1ps
`default_nettype none
module mbx_crc
  import mbx_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        start_in,
  input  wire logic        byte_vld_in,
  input  wire logic [7:0]  byte_in,
  output logic      [15:0] crc_out
);
  logic [15:0] crc;
  logic [15:0] next_crc;

  always_comb begin
    next_crc = (start_in ? CRC_INIT : crc) ^ {8'h00, byte_in};
    for (int i = 0; i < 8; i++) begin
      next_crc = next_crc[0] ? ((next_crc >> 1) ^ CRC_POLY) : (next_crc >> 1);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      crc <= CRC_INIT;
    end else if (byte_vld_in) begin
      crc <= next_crc;
    end else if (start_in) begin
      crc <= CRC_INIT;
    end
  end

  assign crc_out = crc;
endmodule // mbx_crc
`default_nettype wire

// ---- mbx_master_model.sv ----
// Purpose: fieldbus master that frames a request and drains the reply
// Assumes: outputs change on the falling edge only
// Notes:   slow mode stalls the drain on every other cycle
`timescale 1ns/1ps
`default_nettype none
module mbx_master_model
  import mbx_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic byte_vld_in,
  input  wire logic reply_done_in,
  input  wire logic [7:0] byte_in,
  output logic      rx_start_out,
  output logic      rx_byte_vld_out,
  output logic [7:0] rx_byte_out,
  output logic      req_vld_out,
  output mbx_req_s  req_out,
  output logic      byte_rdy_out
);
  int n_bytes;
  // Reply as received, and the running sum over it; zero when intact
  logic [7:0]  rep [8];
  logic [15:0] rep_crc;

  initial begin
    rx_start_out    = 1'b0;
    rx_byte_vld_out = 1'b0;
    rx_byte_out     = 8'h00;
    req_vld_out     = 1'b0;
    req_out         = '0;
    byte_rdy_out    = 1'b0;
  end

  // Own CRC, but it shares CRC_POLY with the design, so a wrong polynomial would hide
  function automatic logic [15:0] crc_add(logic [15:0] c, logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  task automatic send(input logic [7:0] f, input logic [15:0] a, d,
                      input logic [3:0] len, input logic bad, slow);
    logic [7:0]  fr [8];
    logic [15:0] crc;
    logic        done;
    fr = '{8'h01, f, a[15:8], a[7:0], d[15:8], d[7:0], 8'h00, 8'h00};
    crc = CRC_INIT;
    for (int i = 0; i < 6; i++) begin
      crc = crc_add(crc, fr[i]);
    end
    if (bad) begin
      crc = crc ^ 16'h0101;
    end
    fr[6] = crc[7:0];
    fr[7] = crc[15:8];
    @(negedge mclk_in);
    rx_start_out = 1'b1;
    @(negedge mclk_in);
    rx_start_out = 1'b0;
    for (int i = 0; i < 8; i++) begin
      rx_byte_vld_out = 1'b1;
      rx_byte_out     = fr[i];
      @(negedge mclk_in);
    end
    rx_byte_vld_out = 1'b0;
    req_vld_out     = 1'b1;
    req_out         = '{8'h01, f, a, d, crc, len};
    @(negedge mclk_in);
    req_vld_out = 1'b0;
    n_bytes     = 0;
    rep_crc     = CRC_INIT;
    done        = 1'b0;
    for (int k = 0; k < 200 && !done; k++) begin
      byte_rdy_out = slow ? k[0] : 1'b1;
      #1;
      if (byte_vld_in && byte_rdy_out) begin
        if (n_bytes < 8) begin
          rep[n_bytes] = byte_in;
        end
        rep_crc = crc_add(rep_crc, byte_in);
        n_bytes++;
      end
      done = reply_done_in;
      @(negedge mclk_in);
    end
    byte_rdy_out = 1'b0;
  endtask
endmodule // mbx_master_model
`default_nettype wire

// ---- tb_modbus_exception_and_scaling.sv ----
// Purpose: self-checking bench for the request checker and scaler
// Assumes: 40 MHz clock, inputs moved on the falling edge
// Notes:   reply bytes captured by the master model, judged byte by byte
`timescale 1ns/1ps
`default_nettype none
module tb_modbus_exception_and_scaling;
  import mbx_pkg::*;
  logic        mclk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        rx_start, rx_vld, req_vld, byte_rdy, fault, running;
  logic        busy, byte_vld, reply_done;
  logic [7:0]  rx_byte, byte_out, err;
  logic [15:0] pwd = 16'h0000;
  mbx_req_s    req;
  mbx_par_s    par = '0;
  mbx_wr_s     wr;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n_store = 0;
  int          cyc = 0;
  logic [15:0] st_val = 16'h0000;

  initial fault = 1'b0;
  initial running = 1'b0;
  always #12.5 mclk_in = ~mclk_in;

  mbx_master_model m (.mclk_in(mclk_in), .byte_vld_in(byte_vld),
    .reply_done_in(reply_done), .rx_start_out(rx_start),
    .rx_byte_vld_out(rx_vld), .rx_byte_out(rx_byte), .req_vld_out(req_vld),
    .req_out(req), .byte_rdy_out(byte_rdy), .byte_in(byte_out));

  mbx_exc_scale #(.MAX_QTY(12)) dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .rx_start_in(rx_start), .rx_byte_vld_in(rx_vld), .rx_byte_in(rx_byte),
    .req_vld_in(req_vld), .req_in(req), .par_in(par), .fault_in(fault),
    .running_in(running), .user_password_setting_in(pwd),
    .byte_rdy_in(byte_rdy), .busy_out(busy), .byte_vld_out(byte_vld),
    .byte_out(byte_out), .reply_done_out(reply_done), .wr_out(wr),
    .err_out(err));

  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (wr.store === 1'b1) begin
      n_store <= n_store + 1;
      st_val  <= wr.value;
    end
    // Ceiling well above the roughly 600 cycles the tests need
    if (cyc == 8000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  end

  task automatic check(input logic [15:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  // One request; judges error code, reply length and store count
  task automatic run(input logic [7:0] f, input logic [15:0] a, d,
                     input logic [7:0] ec, input logic [3:0] nb,
                     input int ns, input logic bad = 1'b0,
                     input logic [3:0] len = 4'h8, input logic slow = 1'b0);
    int s0;
    s0 = n_store;
    m.send(f, a, d, len, bad, slow);
    check({8'h00, err}, {8'h00, ec}, "error code");
    check(16'(m.n_bytes), {12'h000, nb}, "reply bytes");
    check(16'(n_store - s0), 16'(ns), "stores");
    check({8'h00, m.rep[0]}, 16'h0001, "slave address");
    check({8'h00, m.rep[1]}, {8'h00, (ec != EC_NONE) ? (f | FC_EXC_BIT) : f}, "func");
    check(m.rep_crc, RESET_WORD, "reply crc");
    if (ec != EC_NONE) begin
      check({8'h00, m.rep[2]}, {8'h00, ec}, "error byte");
    end else if (f == FC_WRITE) begin
      check({m.rep[2], m.rep[3]}, a, "echo address");
      check({m.rep[4], m.rep[5]}, d, "echo data");
    end else begin
      check({8'h00, m.rep[2]}, 16'h0002, "byte count");
    end
  endtask

  task automatic setp(input logic ok, ro, rl, rg, pw, input logic [3:0] dec);
    par = '{ok, ro, rl, rg, pw, dec, 16'h0005};
  endtask

  task automatic t_scale;
    setp(1, 0, 0, 1, 0, 4'h1);
    run(FC_WRITE, 16'h0114, 16'd50, EC_NONE, ECHO_LEN, 1);
    check(st_val, 16'd5, "scaled store");
    setp(1, 0, 0, 1, 0, 4'h2);
    run(FC_WRITE, 16'h0003, 16'd10000, EC_NONE, ECHO_LEN, 1, 0, 8, 1);
    check(st_val, 16'd100, "scaled store");
    setp(1, 0, 0, 1, 0, 4'h0);
    run(FC_WRITE, 16'h0003, 16'd7, EC_NONE, ECHO_LEN, 1);
    check(st_val, 16'd7, "unscaled store");
    $display("t_scale done");
  endtask

  task automatic t_read;
    run(FC_READ, 16'h2100, 16'd1, EC_NONE, READ_LEN, 0);
    run(FC_READ, 16'h2100, 16'd0, EC_BAD_DATA, EXC_LEN, 0);
    run(FC_READ, 16'h2100, 16'd13, EC_BAD_ADDR, EXC_LEN, 0);
    run(FC_READ, 16'h2100, 16'd12, EC_NONE, READ_LEN, 0);
    setp(1, 0, 0, 1, 0, 4'h1);
    run(FC_READ, 16'h0114, 16'd1, EC_NONE, READ_LEN, 0);
    check({m.rep[3], m.rep[4]}, 16'd50, "scaled read");
    setp(0, 0, 0, 1, 0, 4'h0);
    run(FC_READ, 16'h7fff, 16'd1, EC_BAD_ADDR, EXC_LEN, 0, 0, 8, 1);
    $display("t_read done");
  endtask

  task automatic t_faults;
    setp(1, 0, 0, 1, 0, 4'h0);
    run(8'h2b, 16'h0001, 16'd1, EC_BAD_FUNC, EXC_LEN, 0);
    run(FC_READ, 16'h0001, 16'd1, EC_FRAME, EXC_LEN, 0, 1);
    run(FC_READ, 16'h0001, 16'd1, EC_FRAME, EXC_LEN, 0, 0, 7);
    fault = 1'b1;
    run(FC_READ, 16'h0001, 16'd1, EC_BAD_FUNC, EXC_LEN, 0);
    fault = 1'b0;
    setp(1, 1, 0, 1, 0, 4'h0);
    run(FC_WRITE, 16'h3000, 16'd1, EC_READ_ONLY, EXC_LEN, 0);
    setp(1, 0, 1, 1, 0, 4'h0);
    running = 1'b1;
    run(FC_WRITE, 16'h0001, 16'd1, EC_RUN_LOCK, EXC_LEN, 0, 0, 8, 1);
    running = 1'b0;
    run(FC_WRITE, 16'h0001, 16'd1, EC_NONE, ECHO_LEN, 1);
    setp(1, 0, 0, 0, 0, 4'h0);
    run(FC_WRITE, 16'h0001, 16'd3, EC_OP_FAIL, EXC_LEN, 0);
    setp(1, 0, 0, 1, 0, 4'h0);
    run(FC_WRITE, 16'h0001, 16'd2, EC_NONE, ECHO_LEN, 1);
    $display("t_faults done");
  endtask

  task automatic t_pwd;
    pwd = 16'h1234;
    run(FC_READ, 16'h0001, 16'd1, EC_SYS_LOCKED, EXC_LEN, 0);
    setp(1, 0, 0, 1, 1, 4'h0);
    run(FC_WRITE, 16'h0004, 16'h1111, EC_PASSWORD, EXC_LEN, 0);
    run(FC_WRITE, 16'h0004, 16'h1234, EC_NONE, ECHO_LEN, 0);
    setp(1, 0, 0, 1, 0, 4'h0);
    run(FC_READ, 16'h0001, 16'd1, EC_NONE, READ_LEN, 0);
    // Unlock must not survive a reset
    rst_n_in = 1'b0;
    @(negedge mclk_in);
    rst_n_in = 1'b1;
    check({8'h00, err}, {8'h00, EC_NONE}, "error after reset");
    run(FC_READ, 16'h0001, 16'd1, EC_SYS_LOCKED, EXC_LEN, 0);
    $display("t_pwd done");
  endtask

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(negedge mclk_in);
    rst_n_in = 1'b1;
    @(negedge mclk_in);
    t_scale();
    t_read();
    t_faults();
    t_pwd();
    end_of_test();
  end
endmodule // tb_modbus_exception_and_scaling
`default_nettype wire
